/* File: src/dhf_defines.svh */
// Register offsets, field positions and reset values of the half-block front end
`ifndef DHF_DEFINES_SVH
`define DHF_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DHF_CFG_OFF   4'h0
`define DHF_BYP_OFF   4'h4
`define DHF_SEL_OFF   4'h8
`define DHF_CTL_OFF   4'hC

// ----------------------------------------
// Field positions in the config register
// ----------------------------------------
`define DHF_F_WM      0
`define DHF_F_CAS     2
`define DHF_F_LB      3
`define DHF_F_SUB0    4
`define DHF_F_SUB1    5
`define DHF_F_PIPE    6
`define DHF_F_RT      7
`define DHF_F_DLY     9
`define DHF_CFG_W     10

// ----------------------------------------
// Field positions in the line select register
// ----------------------------------------
`define DHF_F_INSEL   0
`define DHF_F_PPSEL   2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DHF_CFG_RST   10'h000
`define DHF_BYP_RST   8'h00
`define DHF_SEL_RST   4'h0
`define DHF_ZERO18    18'h00000
`define DHF_ZERO37    37'h0000000000

// Operand masks: narrow operands sit in the upper bits, the lsbs padded with zero
`define DHF_MASK9     18'h3FE00
`define DHF_MASK12    18'h3FFC0
`define DHF_MASK18    18'h3FFFF

`endif

/* File: src/dhf_pkg.sv */
// Types shared by the half-block front end
package dhf_pkg;

   // Native multiplier width
   typedef enum logic [1:0] {
      DHF_W9,
      DHF_W12,
      DHF_W18,
      DHF_W36
   } dhf_width_t;

   // Where the downstream stages take the first-stage sum from
   typedef enum logic [1:0] {
      DHF_RT_PIPE,
      DHF_RT_ADD2,
      DHF_RT_RSU,
      DHF_RT_OUTREG
   } dhf_route_t;

endpackage

/* File: src/dhf_mult.sv */
// One 18x18 multiplier with independent operand sign control
`timescale 1ns/100ps
`default_nettype none

module dhf_mult (
   input  wire logic [17:0] op_a,    // Operand A
   input  wire logic [17:0] op_b,    // Operand B
   input  wire logic        sgn_a,   // High: A is two's complement
   input  wire logic        sgn_b,   // High: B is two's complement
   output logic      [35:0] prod,    // Full-precision product
   output logic             prod_sgn // High: product is signed
);

   // ----------------------------------------
   // Operand extension
   // ----------------------------------------
   // One extra bit lets unsigned and signed share one signed multiplier
   logic signed [18:0] ext_a;   // A with sign or zero bit on top
   logic signed [18:0] ext_b;   // B with sign or zero bit on top
   logic signed [37:0] full;    // Raw 19x19 product

   assign ext_a = $signed({sgn_a & op_a[17], op_a});
   assign ext_b = $signed({sgn_b & op_b[17], op_b});

   // ----------------------------------------
   // Product
   // ----------------------------------------
   // Every sign mix fits in 36 bits, so the top bits are only copies
   assign full     = ext_a * ext_b;
   assign prod     = full[35:0];
   assign prod_sgn = sgn_a | sgn_b;

endmodule
`default_nettype wire

/* File: src/dhf_half.sv */
// Half-block front end: input banks, four multipliers, two adders, pipeline
//
// Functional notes
// - Registers capture on rising edge, reset zero.
// - Each operand registered or bypassed, per configuration.
// - Input banks use selectable clock, enable, clear.
// - Nine 18-bit banks, eight feed multipliers.
// - Ninth bank delays the cascade chain output.
// - A source fixed before operation.
// - Cascade shifts A down the lanes.
// - First B selects routing or loopback.
// - Cascade and loopback only in 18-bit mode.
// - Native 9/12/18/36 widths, narrower padded.
// - Sign inputs high mean signed operand.
// - Product signed if either operand signed.
// - Full precision except loopback and adder sum.
// - Two adders, each over two products.
// - Add or subtract fixed before operation.
// - Sum routed to pipe, adder, RSU, output.
// - Pipeline stage optional, adds one cycle.
// - Halves share clock, enable, clear lines.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "dhf_defines.svh"

module dhf_half (
   input  wire logic                clk,          // System clock
   input  wire logic                rst,          // Async reset, high
   input  wire logic [3:0]          clk_line,     // Shared clock qualifiers
   input  wire logic [3:0]          ena,          // Shared clock enables
   input  wire logic [3:0]          aclr,         // Shared async clears
   input  wire logic [3:0]          addr,         // Register byte address
   input  wire logic [31:0]         wdata,        // Register write data
   input  wire logic                wr_en,        // Register write strobe
   input  wire logic                rd_en,        // Register read strobe
   output logic      [31:0]         rdata,        // Read data, next cycle
   input  wire logic [71:0]         a_in,         // A operands, lane 0 low
   input  wire logic [71:0]         b_in,         // B operands, lane 0 low
   input  wire logic [17:0]         scan_in,      // Cascade from previous half
   input  wire logic [17:0]         loop_fb,      // Top 18 result bits
   input  wire logic                signa,        // A operands signed
   input  wire logic                signb,        // B operands signed
   output logic      [17:0]         scan_out,     // Cascade to next half
   output logic      [17:0]         scan_dly_out, // Delayed cascade output
   output logic      [36:0]         sum0,         // First adder result
   output logic      [36:0]         sum1,         // Second adder result
   output logic                     sum0_sgn,     // First sum signed
   output logic                     sum1_sgn,     // Second sum signed
   output logic      [143:0]        prod_out,     // Raw products, lane 0 low
   output var dhf_pkg::dhf_route_t  sum_route     // Downstream sum source
);

   // ----------------------------------------
   // Software-visible configuration
   // ----------------------------------------
   logic [`DHF_CFG_W-1:0] cfg_r;   // Mode bits
   logic [7:0]            byp_r;   // Per-operand bypass, A even, B odd
   logic [3:0]            sel_r;   // Line select for inputs and pipe
   logic                  run_r;   // High: static settings locked
   logic [31:0]           rd_nxt;  // Read mux
   logic                  cfg_wr;  // Write to a lockable register

   dhf_pkg::dhf_width_t   wm;      // Active width
   logic                  cas_act; // Cascade in effect
   logic                  lb_act;  // Loopback in effect
   logic                  pipe_en; // Pipeline stage inserted
   logic [17:0]           mask;    // Lsb padding mask

   assign wm       = dhf_pkg::dhf_width_t'(cfg_r[`DHF_F_WM+1:`DHF_F_WM]);
   assign pipe_en  = cfg_r[`DHF_F_PIPE];
   assign sum_route = dhf_pkg::dhf_route_t'(cfg_r[`DHF_F_RT+1:`DHF_F_RT]);

   // Shift chain and loopback only exist at 18 bits
   assign cas_act = cfg_r[`DHF_F_CAS] & (wm == dhf_pkg::DHF_W18);
   assign lb_act  = cfg_r[`DHF_F_LB] & (wm == dhf_pkg::DHF_W18);

   // Narrow widths keep the upper bits and zero the rest
   always_comb begin
      case (wm)
         dhf_pkg::DHF_W9:  mask = `DHF_MASK9;
         dhf_pkg::DHF_W12: mask = `DHF_MASK12;
         default:          mask = `DHF_MASK18;
      endcase
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Mode writes are dropped while running: these paths are static
   assign cfg_wr = wr_en & ~run_r;

   // Mode register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r <= `DHF_CFG_RST;
      end else if (cfg_wr && addr == `DHF_CFG_OFF) begin
         cfg_r <= wdata[`DHF_CFG_W-1:0];
      end
   end

   // Bypass register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         byp_r <= `DHF_BYP_RST;
      end else if (cfg_wr && addr == `DHF_BYP_OFF) begin
         byp_r <= wdata[7:0];
      end
   end

   // Line select register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_r <= `DHF_SEL_RST;
      end else if (cfg_wr && addr == `DHF_SEL_OFF) begin
         sel_r <= wdata[3:0];
      end
   end

   // Run bit stays writable so software can unlock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_r <= 1'b0;
      end else if (wr_en && addr == `DHF_CTL_OFF) begin
         run_r <= wdata[0];
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_comb begin
      rd_nxt = 32'h00000000;
      case (addr)
         `DHF_CFG_OFF: rd_nxt[`DHF_CFG_W-1:0] = cfg_r;
         `DHF_BYP_OFF: rd_nxt[7:0] = byp_r;
         `DHF_SEL_OFF: rd_nxt[3:0] = sel_r;
         // Status: run, cascade, loopback, sum signs
         `DHF_CTL_OFF: rd_nxt[4:0] = {sum1_sgn, sum0_sgn, lb_act, cas_act, run_r};
         default:      rd_nxt = 32'h00000000; // Unmapped reads zero
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else if (rd_en) begin
         rdata <= rd_nxt;
      end else begin
         rdata <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // Clock line selection
   // ----------------------------------------
   // Lines are shared with the other half; only the choice is local
   logic [1:0] in_sel;   // Line for input banks
   logic [1:0] pp_sel;   // Line for pipeline
   logic       in_load;  // Input banks capture
   logic       pp_load;  // Pipeline captures
   logic       in_clr;   // Input banks clear
   logic       pp_clr;   // Pipeline clears

   assign in_sel  = sel_r[`DHF_F_INSEL+1:`DHF_F_INSEL];
   assign pp_sel  = sel_r[`DHF_F_PPSEL+1:`DHF_F_PPSEL];
   assign in_load = clk_line[in_sel] & ena[in_sel];
   assign pp_load = clk_line[pp_sel] & ena[pp_sel];
   // Clear is a reset term, so it zeroes without waiting for an edge
   assign in_clr  = rst | aclr[in_sel];
   assign pp_clr  = rst | aclr[pp_sel];

   // ----------------------------------------
   // Input banks and multipliers, per lane
   // ----------------------------------------
   logic [17:0] a_r [4];   // A banks
   logic [17:0] b_r [4];   // B banks
   logic [17:0] op_a [4];  // A at the multiplier
   logic [17:0] op_b [4];  // B at the multiplier
   logic [35:0] prod [4];  // Products
   logic        psgn [4];  // Product signs

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_lane
         // In 36-bit mode lanes carry AH*BL, AL*BH, AH*BH, AL*BL
         localparam logic HI_A = (i == 0) || (i == 2);
         localparam logic HI_B = (i == 1) || (i == 2);
         logic [17:0] a_src;  // A bank input
         logic [17:0] b_src;  // B bank input
         logic        sa;     // Lane A sign
         logic        sb;     // Lane B sign

         // A comes from routing or the lane above
         if (i == 0) begin : g_top
            assign a_src = cas_act ? scan_in : a_in[17:0];
         end else begin : g_low
            assign a_src = cas_act ? a_r[i-1] : a_in[i*18 +: 18];
         end

         // Only lane 0 B can take the loopback
         if (i == 0) begin : g_lb
            assign b_src = lb_act ? loop_fb : b_in[17:0];
         end else begin : g_nolb
            assign b_src = b_in[i*18 +: 18];
         end

         // A bank
         always_ff @(posedge clk or posedge in_clr) begin
            if (in_clr) begin
               a_r[i] <= `DHF_ZERO18;
            end else if (in_load) begin
               a_r[i] <= a_src;
            end
         end

         // B bank
         always_ff @(posedge clk or posedge in_clr) begin
            if (in_clr) begin
               b_r[i] <= `DHF_ZERO18;
            end else if (in_load) begin
               b_r[i] <= b_src;
            end
         end

         // Bypass skips the bank; a cascaded A always uses its bank
         assign op_a[i] = mask & ((byp_r[2*i] & ~cas_act) ? a_src : a_r[i]);
         assign op_b[i] = mask & (byp_r[2*i+1] ? b_src : b_r[i]);

         // Low halves of a 36-bit operand are always unsigned
         assign sa = (wm == dhf_pkg::DHF_W36) ? (signa & HI_A) : signa;
         assign sb = (wm == dhf_pkg::DHF_W36) ? (signb & HI_B) : signb;

         dhf_mult u_mult (
            .op_a     (op_a[i]),
            .op_b     (op_b[i]),
            .sgn_a    (sa),
            .sgn_b    (sb),
            .prod     (prod[i]),
            .prod_sgn (psgn[i])
         );

         assign prod_out[i*36 +: 36] = prod[i];
      end
   endgenerate

   // ----------------------------------------
   // Ninth bank: cascade delay
   // ----------------------------------------
   logic [17:0] dly_r;  // Delay bank

   // Keeps the shift chain in step with the chained result path
   always_ff @(posedge clk or posedge in_clr) begin
      if (in_clr) begin
         dly_r <= `DHF_ZERO18;
      end else if (in_load && cfg_r[`DHF_F_DLY]) begin
         dly_r <= a_r[3];
      end
   end

   assign scan_out     = a_r[3];
   assign scan_dly_out = dly_r;

   // ----------------------------------------
   // First-stage adders
   // ----------------------------------------
   // Widen by sign or zero per product
   function automatic logic [36:0] ext37(input logic [35:0] p, input logic s);
      ext37 = s ? {p[35], p} : {1'b0, p};
   endfunction

   logic [36:0] e0, e1, e2, e3;  // Widened products
   logic [36:0] s0_c;            // Adder 0 combinational
   logic [36:0] s1_c;            // Adder 1 combinational

   assign e0 = ext37(prod[0], psgn[0]);
   assign e1 = ext37(prod[1], psgn[1]);
   assign e2 = ext37(prod[2], psgn[2]);
   assign e3 = ext37(prod[3], psgn[3]);

   // Unsigned sums wrap at 37 bits: the user keeps them in range
   assign s0_c = cfg_r[`DHF_F_SUB0] ? (e0 - e1) : (e0 + e1);
   assign s1_c = cfg_r[`DHF_F_SUB1] ? (e2 - e3) : (e2 + e3);

   assign sum0_sgn = psgn[0] | psgn[1];
   assign sum1_sgn = psgn[2] | psgn[3];

   // ----------------------------------------
   // Pipeline stage
   // ----------------------------------------
   logic [36:0] p0_r;  // Adder 0 pipeline
   logic [36:0] p1_r;  // Adder 1 pipeline

   // Splits the long path at the cost of one cycle
   always_ff @(posedge clk or posedge pp_clr) begin
      if (pp_clr) begin
         p0_r <= `DHF_ZERO37;
         p1_r <= `DHF_ZERO37;
      end else if (pp_load) begin
         p0_r <= s0_c;
         p1_r <= s1_c;
      end
   end

   assign sum0 = pipe_en ? p0_r : s0_c;
   assign sum1 = pipe_en ? p1_r : s1_c;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   reset_zero_a: assert property (@(posedge clk) $fell(rst) |->
      (a_r[0] == `DHF_ZERO18) && (p0_r == `DHF_ZERO37) && (dly_r == `DHF_ZERO18))
      else $error("bank not zero after reset");

   bypass_path_a: assert property (@(posedge clk) disable iff (rst)
      (byp_r[1] && wm == dhf_pkg::DHF_W18) |-> (op_b[0] == (lb_act ? loop_fb : b_in[17:0])))
      else $error("bypassed B not at multiplier");

   hold_no_load_a: assert property (@(posedge clk) disable iff (rst)
      (!in_load && !in_clr) |=> (in_clr || $stable(a_r[2])))
      else $error("bank changed without enable");

   clear_zero_a: assert property (@(posedge clk) disable iff (rst)
      in_clr |-> (b_r[1] == `DHF_ZERO18))
      else $error("clear did not zero bank");

   cascade_shift_a: assert property (@(posedge clk) disable iff (rst)
      (cas_act && in_load && !in_clr) ##1 !in_clr |-> (a_r[1] == $past(a_r[0])))
      else $error("cascade did not shift");

   loopback_a: assert property (@(posedge clk) disable iff (rst)
      (lb_act && in_load && !in_clr) ##1 !in_clr |-> (b_r[0] == $past(loop_fb)))
      else $error("loopback not captured");

   narrow_mode_a: assert property (@(posedge clk) disable iff (rst)
      (wm != dhf_pkg::DHF_W18) |-> (!cas_act && !lb_act && scan_out == a_r[3]))
      else $error("chain active outside 18-bit mode");

   zero_pad_a: assert property (@(posedge clk) disable iff (rst)
      (wm == dhf_pkg::DHF_W9) |-> (op_a[3][8:0] == 9'h000 && op_b[2][8:0] == 9'h000))
      else $error("narrow operand lsbs not padded");

   static_lock_a: assert property (@(posedge clk) disable iff (rst)
      (run_r && wr_en && addr == `DHF_CFG_OFF) |=> $stable(cfg_r))
      else $error("mode changed while running");

   pipe_delay_a: assert property (@(posedge clk) disable iff (rst)
      (pipe_en && pp_load && !pp_clr) ##1 (pipe_en && !pp_clr) |-> (sum1 == $past(s1_c)))
      else $error("pipeline sum not one cycle late");

   unmapped_a: assert property (@(posedge clk) disable iff (rst)
      (rd_en && addr[1:0] != 2'h0) |=> (rdata == 32'h00000000))
      else $error("unmapped read not zero");

endmodule
`default_nettype wire

/* File: tb/dhf_fabric_model.sv */
// Neighbour half and downstream result register, as seen from one half block
`timescale 1ns/100ps
`default_nettype none

module dhf_fabric_model (
   input  wire logic        clk,      // Shared clock
   input  wire logic        rst,      // Async reset, high
   input  wire logic [3:0]  clk_line, // Shared clock qualifiers
   input  wire logic [3:0]  ena,      // Shared clock enables
   input  wire logic [17:0] feed,     // Fabric data entering the neighbour chain
   input  wire logic [35:0] res_in,   // Downstream result to register
   output logic      [17:0] scan_in,  // Neighbour lane 3 A register
   output logic      [17:0] loop_fb   // Top bits of the registered result
);
   logic [35:0] res_r; // Registered result
   logic        ld;    // Load strobe of line 0

   // Uses line 0, the line the half block takes while its line select is zero
   assign ld = clk_line[0] & ena[0];

   // Cascade comes only from a neighbour chain register, never raw fabric
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scan_in <= 18'h00000;
         res_r   <= 36'h000000000;
      end else if (ld) begin
         scan_in <= feed;
         res_r   <= res_in;
      end
   end

   // Feedback passes a register, so the loop can never close combinationally
   assign loop_fb = res_r[35:18];
endmodule
`default_nettype wire

/* File: tb/dsp_half_block_front_end_tb.sv */
// Self-checking bench of the half-block front end
`timescale 1ns/100ps
`default_nettype none
`include "dhf_defines.svh"

module dsp_half_block_front_end_tb;
   typedef struct {int id; logic [36:0] v;} dhf_exp_t; // Expected result note

   logic                clk      = 1'b0;
   logic                rst      = 1'b1;
   logic [3:0]          clk_line = 4'h0;
   logic [3:0]          ena      = 4'h0;
   logic [3:0]          aclr     = 4'h0;
   logic [3:0]          addr     = 4'h0;
   logic [31:0]         wdata    = 32'h0;
   logic                wr_en    = 1'b0;
   logic                rd_en    = 1'b0;
   logic [71:0]         a_in     = 72'h0;
   logic [71:0]         b_in     = 72'h0;
   logic                signa    = 1'b0;
   logic                signb    = 1'b0;
   logic [17:0]         feed     = 18'h00000;
   logic [35:0]         res_in   = 36'h000000000;
   logic [17:0]         scan_in, loop_fb, scan_out, scan_dly_out;
   logic [31:0]         rdata;
   logic [36:0]         sum0, sum1;
   logic                sum0_sgn, sum1_sgn;
   logic [1:0]          sum_route;
   logic [143:0]        prod_out;
   logic [31:0]         rs       = 32'h0000001E; // Random state
   logic [31:0]         r;
   logic [71:0]         av, bv;   // Current operands
   logic [35:0]         keep;
   logic [36:0]         keep37;
   dhf_exp_t            q[$];     // Pending expectations, oldest first
   dhf_exp_t            e;
   logic [17:0]         h[$];     // Cascade values seen, newest first
   string nm[8] = '{"prod0", "sum0", "sum_sgn", "scan_out", "scan_dly", "rdata", "sum1", "route"};
   int                  n_errors = 0;
   int                  compares = 0;
   int                  i;

   dhf_half u_dhf_half (.clk(clk), .rst(rst), .clk_line(clk_line), .ena(ena), .aclr(aclr),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .a_in(a_in), .b_in(b_in), .scan_in(scan_in), .loop_fb(loop_fb), .signa(signa),
      .signb(signb), .scan_out(scan_out), .scan_dly_out(scan_dly_out), .sum0(sum0),
      .sum1(sum1), .sum0_sgn(sum0_sgn), .sum1_sgn(sum1_sgn), .prod_out(prod_out),
      .sum_route(sum_route));

   dhf_fabric_model u_dhf_fabric_model (.clk(clk), .rst(rst), .clk_line(clk_line),
      .ena(ena), .feed(feed), .res_in(res_in), .scan_in(scan_in), .loop_fb(loop_fb));

   // 100 MHz clock
   always #5 clk = ~clk;

   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   // Reference product; operands widened by their own sign control
   function automatic logic [35:0] mul(input logic [17:0] a, b, input logic sa, sb);
      longint x, y;
      x = sa ? longint'($signed(a)) : longint'(a);
      y = sb ? longint'($signed(b)) : longint'(b);
      return 36'(x * y);
   endfunction

   // Reference first-stage adder k over lanes 2k and 2k+1
   function automatic logic [36:0] esum(input int k, input logic [17:0] m,
                                        input logic sub, sa, sb);
      logic [35:0] p0, p1;
      logic [36:0] e0, e1;
      p0 = mul(av[36*k +: 18] & m, bv[36*k +: 18] & m, sa, sb);
      p1 = mul(av[36*k+18 +: 18] & m, bv[36*k+18 +: 18] & m, sa, sb);
      e0 = (sa | sb) ? {p0[35], p0} : {1'b0, p0};
      e1 = (sa | sb) ? {p1[35], p1} : {1'b0, p1};
      return sub ? e0 - e1 : e0 + e1;
   endfunction

   function automatic logic [36:0] seen(input int id);
      case (id)
         0: return {1'b0, prod_out[35:0]};
         1: return sum0;
         2: return {35'h0, sum1_sgn, sum0_sgn};
         3: return {19'h0, scan_out};
         4: return {19'h0, scan_dly_out};
         6: return sum1;
         7: return {35'h0, sum_route};
         default: return {5'h0, rdata};
      endcase
   endfunction

   task automatic note(input int id, input logic [36:0] v);
      dhf_exp_t t;
      t.id = id;
      t.v = v;
      q.push_back(t);
   endtask

   task automatic check(input string n, input logic [36:0] s, x);
      compares++;
      if (s !== x) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, x, s);
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Bus cycles: one strobe cycle, then an idle edge before the next
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      note(5, {5'h0, x});
   endtask

   // Configuration only sticks while stopped
   task automatic cfgset(input logic [9:0] c, input logic [7:0] y, input logic [3:0] s);
      wr(`DHF_CTL_OFF, 32'h0);
      wr(`DHF_CFG_OFF, {22'h0, c});
      wr(`DHF_BYP_OFF, {24'h0, y});
      wr(`DHF_SEL_OFF, {28'h0, s});
      wr(`DHF_CTL_OFF, 32'h1);
   endtask

   task automatic rand_ops();
      av = 72'({rnd(), rnd(), rnd()});
      bv = 72'({rnd(), rnd(), rnd()});
      a_in <= av;
      b_in <= bv;
   endtask

   // One bypassed operand set; product, sum and sign noted
   task automatic go(input logic [17:0] m, input logic sub, sa, sb);
      @(posedge clk);
      rand_ops();
      signa <= sa; // One sign form for all A lanes of the half
      signb <= sb;
      note(0, {1'b0, mul(av[17:0] & m, bv[17:0] & m, sa, sb)});
      note(1, esum(0, m, sub, sa, sb));
      note(6, esum(1, m, sub, sa, sb));
      note(2, {35'h0, sa | sb, sa | sb});
   endtask

   // Monitor: results settle by the falling edge
   always @(negedge clk) begin
      while (q.size() > 0) begin
         e = q.pop_front();
         check(nm[e.id], seen(e.id), e.v);
      end
   end

   // Watchdog, well past the 150 or so cycles the run needs
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(`DHF_CFG_OFF, 32'h0);
      rd(`DHF_BYP_OFF, 32'h0);
      rd(`DHF_SEL_OFF, 32'h0);
      rd(4'h1, 32'h0);
      clk_line <= 4'h1;
      ena <= 4'h1;
      cfgset(10'h002, 8'hFF, 4'h0);
      wr(`DHF_CFG_OFF, 32'h3FF);
      rd(`DHF_CFG_OFF, 32'h2);
      for (i = 0; i < 8; i++) begin
         go(`DHF_MASK18, 1'b0, i[0], i[1]);
      end
      cfgset(10'h032, 8'hFF, 4'h0);
      go(`DHF_MASK18, 1'b1, 1'b1, 1'b0);
      // Loopback asked in narrow modes must be ignored
      cfgset(10'h008, 8'hFF, 4'h0);
      go(`DHF_MASK9, 1'b0, 1'b1, 1'b0);
      cfgset(10'h009, 8'hFF, 4'h0);
      go(`DHF_MASK12, 1'b0, 1'b0, 1'b1);
      // 36-bit split: the low B half on lane 0 is forced unsigned
      cfgset(10'h003, 8'hFF, 4'h0);
      @(posedge clk);
      rand_ops();
      signb <= 1'b1;
      note(0, {1'b0, mul(av[17:0], bv[17:0], 1'b0, 1'b0)});
      // Registered operands on line 1: load, hold, clear
      cfgset(10'h002, 8'h00, 4'h1);
      @(posedge clk);
      rand_ops();
      signa <= 1'b0;
      signb <= 1'b0;
      clk_line <= 4'h2;
      ena <= 4'h2;
      keep = mul(av[17:0], bv[17:0], 1'b0, 1'b0);
      @(posedge clk);
      rand_ops();
      ena <= 4'hD;
      note(0, {1'b0, keep});
      @(posedge clk);
      note(0, {1'b0, keep});
      @(posedge clk);
      aclr <= 4'h2;
      note(0, 37'h0);
      @(posedge clk);
      aclr <= 4'h0;
      clk_line <= 4'h1;
      ena <= 4'h1;
      // Pipeline adds exactly one edge
      cfgset(10'h142, 8'hFF, 4'h0);
      @(posedge clk);
      rand_ops();
      note(7, 37'h2);
      keep37 = esum(0, `DHF_MASK18, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      rand_ops();
      note(1, keep37);
      keep37 = esum(0, `DHF_MASK18, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      note(1, keep37);
      // Cascade chain with the delay bank
      cfgset(10'h206, 8'h00, 4'h0);
      for (i = 0; i < 9; i++) begin
         @(posedge clk);
         h.push_front(scan_in);
         r = rnd();
         feed <= r[17:0];
         if (i >= 4) begin
            note(3, {19'h0, h[3]});
            note(4, {19'h0, h[4]});
         end
      end
      // Loopback feeds lane 0 B from the registered result
      cfgset(10'h00A, 8'hFF, 4'h0);
      @(posedge clk);
      rand_ops();
      res_in <= av[71:36];
      @(posedge clk);
      note(0, {1'b0, mul(av[17:0], av[71:54], 1'b0, 1'b0)});
      rd(`DHF_CTL_OFF, 32'h5);
      @(negedge clk);
      @(negedge clk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
